// File: rtl/ptp_pkg.sv
// Shared constants and types for the timing-port delay and receive-parse block
package ptp_pkg;
  localparam logic [15:0]  OFS_BANK_SEL  = 16'h0154;
  localparam logic [15:0]  OFS_RX_PARSE  = 16'h0158;
  localparam logic [15:0]  OFS_ASYM_PEER = 16'h015C;
  localparam logic [15:0]  OFS_CAP_INFO  = 16'h0160;
  localparam logic [15:0]  OFS_CMD_CTL   = 16'h0164;
  localparam logic [15:0]  OFS_EVT_CLR   = 16'h0168;

  localparam logic [2:0]   BANK_GENERAL  = 3'h0;
  localparam logic [2:0]   BANK_RX       = 3'h1;
  localparam logic [1:0]   NUM_PORTS     = 2'h3;

  localparam logic [31:0]  BANK_SEL_MASK = 32'h0000_0737;
  localparam logic [31:0]  BANK_SEL_RST  = 32'h0000_0000;
  localparam logic [31:0]  PARSE_MASK    = 32'h0000_7818;
  localparam logic [31:0]  PARSE_RST     = 32'h0000_7018;
  localparam logic [31:0]  ASYM_PEER_RST = 32'h0000_0000;
  localparam logic [2:0]   CNT_RST       = 3'h0;
  localparam logic [2:0]   CNT_MAX       = 3'h7;

  localparam int           BIT_L2_PEER   = 14;
  localparam int           BIT_L2_GEN    = 13;
  localparam int           BIT_IP_PRI    = 12;
  localparam int           BIT_IP_ALT1   = 11;
  localparam int           BIT_IP_CHK    = 4;
  localparam int           BIT_MAC_CHK   = 3;
  localparam int           RX_CNT_LSB    = 0;
  localparam int           TX_CNT_LSB    = 4;

  localparam logic [47:0]  MAC_L2_PEER   = 48'h0180_C200_000E;
  localparam logic [47:0]  MAC_L2_GEN    = 48'h011B_1900_0000;
  localparam logic [47:0]  MAC_V4_PRI    = 48'h0100_5E00_0181;
  localparam logic [47:0]  MAC_V4_ALT1   = 48'h0100_5E00_0182;
  localparam logic [47:0]  MAC_V6_PRI    = 48'h3333_0000_0181;
  localparam logic [47:0]  MAC_V6_ALT1   = 48'h3333_0000_0182;
  localparam logic [31:0]  IP4_PRI       = 32'hE000_0181;
  localparam logic [31:0]  IP4_ALT1      = 32'hE000_0182;
  localparam logic [11:0]  IP6_HEAD      = 12'hFF0;
  localparam logic [111:0] IP6_PRI_TAIL  = 112'h181;
  localparam logic [111:0] IP6_ALT1_TAIL = 112'h182;

  typedef enum logic [1:0] {
    KIND_OTHER = 2'b00,
    KIND_L2    = 2'b01,
    KIND_IPV4  = 2'b10,
    KIND_IPV6  = 2'b11
  } ptp_kind_t;

  typedef struct packed {
    logic         valid;
    logic [1:0]   port;
    ptp_kind_t    kind;
    logic [47:0]  dmac;
    logic [127:0] ip_dest;
  } ptp_rx_frame_t;
endpackage

// File: rtl/ptp_dly_mem.sv
// Per-port asymmetry and peer delay words with two registered read ports
`timescale 1ns/1ps
module ptp_dly_mem
  import ptp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wbe_i,
  input  wire logic [1:0]  raddr_a_i,
  output logic      [31:0] rdata_a_o,
  input  wire logic [1:0]  raddr_b_i,
  output logic      [31:0] rdata_b_o
);
  logic [31:0] mem [4];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mem[i] <= ASYM_PEER_RST;
      end
    end
    else if (we_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wbe_i[b])
        begin
          mem[waddr_i][8*b +: 8] <= wdata_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_a_o <= ASYM_PEER_RST;
      rdata_b_o <= ASYM_PEER_RST;
    end
    else
    begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule

// File: rtl/ptp_port_delay_parse.sv
// Timing-port delay settings, stamp counts and receive-parse matching
`timescale 1ns/1ps
module ptp_port_delay_parse
(
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_I,
  input  wire logic [15:0]            WB_ADR_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic                   WB_WE_I,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  output logic                        WB_ACK_O,
  input  wire ptp_pkg::ptp_rx_frame_t RX_FRAME_I,
  input  wire logic                   TX_SENT_I,
  input  wire logic [1:0]             TX_PORT_I,
  input  wire logic [1:0]             DLY_PORT_I,
  output logic signed [15:0]          DLY_ASYM_O,
  output logic      [15:0]            DLY_PEER_O,
  output logic                        RX_MATCH_O,
  output logic                        TIMING_ENABLE_O
);
  import ptp_pkg::*;

  logic        pend;
  logic        ack;
  logic        wr;
  logic [31:0] bank_sel;
  logic [2:0]  bank;
  logic [1:0]  port;
  logic        port_ok;
  logic [31:0] parse [3];
  logic [2:0]  rx_cnt [3];
  logic [2:0]  tx_cnt [3];
  logic [2:0]  rx_inc;
  logic [2:0]  tx_inc;
  logic [2:0]  rx_dec;
  logic [2:0]  tx_dec;
  logic        cmd_en;
  logic        mem_we;
  logic [31:0] mem_rd_a;
  logic [31:0] mem_rd_b;
  logic [31:0] cfg;
  logic        mac_ok;
  logic        ip_ok;
  logic        rx_hit;

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] step(input logic [2:0] c, input logic up, input logic dn);
    logic [2:0] r;
    r = c;
    if (up && !dn && c != CNT_MAX)
    begin
      r = c + 3'h1;
    end
    else if (dn && !up && c != CNT_RST)
    begin
      r = c - 3'h1;
    end
    return r;
  endfunction

  function automatic logic v6_hit(input logic [127:0] ip, input logic [111:0] tail);
    return {ip[127:116], ip[111:0]} == {IP6_HEAD, tail};
  endfunction

  assign bank     = bank_sel[2:0];
  assign port     = bank_sel[5:4];
  assign port_ok  = port < NUM_PORTS;
  assign wr       = pend && WB_WE_I;
  assign WB_ACK_O = ack;
  assign TIMING_ENABLE_O = cmd_en;

  // Request taken one edge after it appears, answered on the next
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      pend <= 1'b0;
      ack  <= 1'b0;
    end
    else
    begin
      pend <= WB_CYC_I && WB_STB_I && !pend && !ack;
      ack  <= pend;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      bank_sel <= BANK_SEL_RST;
    end
    else if (wr && WB_ADR_I == OFS_BANK_SEL)
    begin
      bank_sel <= wmask(bank_sel, WB_DAT_I, WB_SEL_I) & BANK_SEL_MASK;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      cmd_en <= 1'b0;
    end
    else if (wr && WB_ADR_I == OFS_CMD_CTL && WB_SEL_I[0])
    begin
      cmd_en <= WB_DAT_I[0];
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      for (int p = 0; p < 3; p++)
      begin
        parse[p] <= PARSE_RST;
      end
    end
    else if (wr && WB_ADR_I == OFS_RX_PARSE && bank == BANK_RX && port_ok)
    begin
      parse[port] <= wmask(parse[port], WB_DAT_I, WB_SEL_I) & PARSE_MASK;
    end
  end

  assign mem_we = wr && WB_ADR_I == OFS_ASYM_PEER && bank == BANK_GENERAL && port_ok;

  ptp_dly_mem u_mem (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .we_i      (mem_we),
    .waddr_i   (port),
    .wdata_i   (WB_DAT_I),
    .wbe_i     (WB_SEL_I),
    .raddr_a_i (port),
    .rdata_a_o (mem_rd_a),
    .raddr_b_i (DLY_PORT_I),
    .rdata_b_o (mem_rd_b)
  );

  // Positive asymmetry: master-to-slave path is the longer one
  assign DLY_ASYM_O = $signed(mem_rd_b[31:16]);
  assign DLY_PEER_O = mem_rd_b[15:0];

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      WB_DAT_O <= 32'h0000_0000;
    end
    else if (pend)
    begin
      WB_DAT_O <= 32'h0000_0000;
      case (WB_ADR_I)
        OFS_BANK_SEL:  WB_DAT_O <= bank_sel;
        OFS_RX_PARSE:  WB_DAT_O <= (bank == BANK_RX && port_ok) ? parse[port] : 32'h0000_0000;
        OFS_ASYM_PEER: WB_DAT_O <= (bank == BANK_GENERAL && port_ok) ? mem_rd_a : 32'h0000_0000;
        OFS_CAP_INFO:
          if (bank == BANK_GENERAL && port_ok)
          begin
            WB_DAT_O <= {25'h0, tx_cnt[port], 1'b0, rx_cnt[port]};
          end
        OFS_CMD_CTL:   WB_DAT_O <= {31'h0, cmd_en};
        default:       WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // Receive parse against the enabled well-known destinations
  always_comb
  begin
    cfg    = (RX_FRAME_I.port < NUM_PORTS) ? parse[RX_FRAME_I.port] : 32'h0000_0000;
    mac_ok = 1'b0;
    ip_ok  = 1'b0;
    case (RX_FRAME_I.kind)
      KIND_L2:
      begin
        mac_ok = !cfg[BIT_MAC_CHK]
               || (cfg[BIT_L2_PEER] && RX_FRAME_I.dmac == MAC_L2_PEER)
               || (cfg[BIT_L2_GEN] && RX_FRAME_I.dmac == MAC_L2_GEN);
        ip_ok  = 1'b1;
      end
      KIND_IPV4:
      begin
        mac_ok = !cfg[BIT_MAC_CHK]
               || (cfg[BIT_IP_PRI] && RX_FRAME_I.dmac == MAC_V4_PRI)
               || (cfg[BIT_IP_ALT1] && RX_FRAME_I.dmac == MAC_V4_ALT1);
        ip_ok  = !cfg[BIT_IP_CHK]
               || (cfg[BIT_IP_PRI] && RX_FRAME_I.ip_dest[31:0] == IP4_PRI)
               || (cfg[BIT_IP_ALT1] && RX_FRAME_I.ip_dest[31:0] == IP4_ALT1);
      end
      KIND_IPV6:
      begin
        mac_ok = !cfg[BIT_MAC_CHK]
               || (cfg[BIT_IP_PRI] && RX_FRAME_I.dmac == MAC_V6_PRI)
               || (cfg[BIT_IP_ALT1] && RX_FRAME_I.dmac == MAC_V6_ALT1);
        ip_ok  = !cfg[BIT_IP_CHK]
               || (cfg[BIT_IP_PRI] && v6_hit(RX_FRAME_I.ip_dest, IP6_PRI_TAIL))
               || (cfg[BIT_IP_ALT1] && v6_hit(RX_FRAME_I.ip_dest, IP6_ALT1_TAIL));
      end
      default:
      begin
        mac_ok = 1'b0;
        ip_ok  = 1'b0;
      end
    endcase
    rx_hit = RX_FRAME_I.valid && cmd_en && RX_FRAME_I.port < NUM_PORTS && mac_ok && ip_ok;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      RX_MATCH_O <= 1'b0;
    end
    else
    begin
      RX_MATCH_O <= rx_hit;
    end
  end

  // Write-one on the event-clear lanes releases one pending stamp per port
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      rx_inc[p] = rx_hit && RX_FRAME_I.port == p[1:0];
      tx_inc[p] = TX_SENT_I && TX_PORT_I == p[1:0];
      rx_dec[p] = wr && WB_ADR_I == OFS_EVT_CLR && WB_SEL_I[0] && WB_DAT_I[RX_CNT_LSB + p];
      tx_dec[p] = wr && WB_ADR_I == OFS_EVT_CLR && WB_SEL_I[0] && WB_DAT_I[TX_CNT_LSB + p];
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      for (int p = 0; p < 3; p++)
      begin
        rx_cnt[p] <= CNT_RST;
        tx_cnt[p] <= CNT_RST;
      end
    end
    else
    begin
      for (int p = 0; p < 3; p++)
      begin
        rx_cnt[p] <= step(rx_cnt[p], rx_inc[p], rx_dec[p]);
        tx_cnt[p] <= step(tx_cnt[p], tx_inc[p], tx_dec[p]);
      end
    end
  end

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence s_new_req;
    WB_CYC_I && WB_STB_I && !pend && !ack;
  endsequence

  sequence s_frame1(ptp_kind_t k, logic [47:0] mac);
    RX_FRAME_I.valid && cmd_en && RX_FRAME_I.port == 2'h1
      && RX_FRAME_I.kind == k && RX_FRAME_I.dmac == mac;
  endsequence

  chk_bus_answer_two: assert property (s_new_req |-> ##1 pend ##1 (ack && !pend))
    else $error("bus answer not two cycles after request");
  chk_l2_peer_accept: assert property (s_frame1(KIND_L2, MAC_L2_PEER)
      ##0 parse[1][BIT_L2_PEER] |=> RX_MATCH_O)
    else $error("layer-2 peer address not accepted");
  chk_l2_gen_accept: assert property (s_frame1(KIND_L2, MAC_L2_GEN)
      ##0 parse[1][BIT_L2_GEN] |=> RX_MATCH_O)
    else $error("layer-2 general address not accepted");
  chk_v4_primary_hit: assert property (s_frame1(KIND_IPV4, MAC_V4_PRI)
      ##0 (parse[1][BIT_IP_PRI] && RX_FRAME_I.ip_dest[31:0] == IP4_PRI) |=> RX_MATCH_O)
    else $error("IPv4 primary address not accepted");
  chk_v6_any_scope: assert property (s_frame1(KIND_IPV6, MAC_V6_PRI)
      ##0 (parse[1][BIT_IP_PRI] && v6_hit(RX_FRAME_I.ip_dest, IP6_PRI_TAIL)) |=> RX_MATCH_O)
    else $error("IPv6 primary address not accepted");
  chk_v6_alt1_hit: assert property (s_frame1(KIND_IPV6, MAC_V6_ALT1)
      ##0 (parse[1][BIT_IP_ALT1] && v6_hit(RX_FRAME_I.ip_dest, IP6_ALT1_TAIL)) |=> RX_MATCH_O)
    else $error("IPv6 alternate address not accepted");
  chk_alt1_disabled: assert property (s_frame1(KIND_IPV4, MAC_V4_ALT1)
      ##0 (!parse[1][BIT_IP_ALT1] && parse[1][BIT_MAC_CHK]) |=> !RX_MATCH_O)
    else $error("disabled alternate address accepted");
  chk_ip_check_miss: assert property (RX_FRAME_I.valid
      && RX_FRAME_I.port == 2'h1 && RX_FRAME_I.kind == KIND_IPV4 && parse[1][BIT_IP_CHK]
      && !(parse[1][BIT_IP_PRI] && RX_FRAME_I.ip_dest[31:0] == IP4_PRI)
      && !(parse[1][BIT_IP_ALT1] && RX_FRAME_I.ip_dest[31:0] == IP4_ALT1)
      |=> !RX_MATCH_O)
    else $error("IPv4 frame with wrong IP accepted");
  chk_mac_check_off: assert property (RX_FRAME_I.valid && cmd_en
      && RX_FRAME_I.port == 2'h1 && RX_FRAME_I.kind == KIND_L2 && !parse[1][BIT_MAC_CHK]
      |=> RX_MATCH_O)
    else $error("layer-2 frame refused with MAC check off");
  chk_rx_count_up: assert property (rx_inc[1] && !rx_dec[1]
      && rx_cnt[1] != CNT_MAX |=> rx_cnt[1] == $past(rx_cnt[1]) + 3'h1)
    else $error("receive stamp count did not rise");
  chk_tx_count_down: assert property (tx_dec[2] && !tx_inc[2]
      && tx_cnt[2] != CNT_RST |=> tx_cnt[2] == $past(tx_cnt[2]) - 3'h1)
    else $error("transmit stamp count did not fall");
  chk_count_ceiling: assert property (tx_cnt[2] == CNT_MAX && !tx_dec[2]
      |=> tx_cnt[2] == CNT_MAX)
    else $error("transmit stamp count wrapped");
  chk_count_floor: assert property (tx_cnt[0] == CNT_RST && !tx_inc[0]
      |=> tx_cnt[0] == CNT_RST)
    else $error("transmit stamp count went below zero");
endmodule

// File: verification/ptp_port_delay_parse_tb_top.sv
// Self-checking testbench for the timing-port delay and receive-parse block
`timescale 1ns/1ps
module ptp_port_delay_parse_tb_top;
  import ptp_pkg::*;
  logic          clk;
  logic          rst;
  logic [15:0]   adr;
  logic [31:0]   dat_w;
  logic [31:0]   dat_r;
  logic [3:0]    sel;
  logic          we;
  logic          cyc;
  logic          stb;
  logic          ack;
  ptp_rx_frame_t rx_frame;
  logic          tx_sent;
  logic [1:0]    tx_port;
  logic [1:0]    dly_port;
  logic [15:0]   dly_asym;
  logic [15:0]   dly_peer;
  logic          rx_match;
  logic          timing_en;
  int            num_errors;
  int            compares;

  ptp_port_delay_parse DUT (
    .CLK_SYS_I       (clk),
    .RST_I           (rst),
    .WB_ADR_I        (adr),
    .WB_DAT_I        (dat_w),
    .WB_DAT_O        (dat_r),
    .WB_SEL_I        (sel),
    .WB_WE_I         (we),
    .WB_CYC_I        (cyc),
    .WB_STB_I        (stb),
    .WB_ACK_O        (ack),
    .RX_FRAME_I      (rx_frame),
    .TX_SENT_I       (tx_sent),
    .TX_PORT_I       (tx_port),
    .DLY_PORT_I      (dly_port),
    .DLY_ASYM_O      (dly_asym),
    .DLY_PEER_O      (dly_peer),
    .RX_MATCH_O      (rx_match),
    .TIMING_ENABLE_O (timing_en)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // One classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk("ack pulse", 32'h0, {31'h0, ack});
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(input string n, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(n, e, q);
  endtask

  task automatic pick(input logic [1:0] p, input logic [2:0] b);
    wr(OFS_BANK_SEL, {26'h0, p, 1'b0, b});
  endtask

  task automatic cnt_chk(input logic [1:0] p, input logic [2:0] t, input logic [2:0] r);
    pick(p, BANK_GENERAL);
    rd_chk("stamp counts", OFS_CAP_INFO, {25'h0, t, 1'b0, r});
  endtask

  // Frame pulse, then match is looked at in the following cycle
  task automatic frame(input logic [1:0] p, input ptp_kind_t k, input logic [47:0] m,
                       input logic [127:0] ip, input logic e);
    rx_frame <= '{valid: 1'b1, port: p, kind: k, dmac: m, ip_dest: ip};
    @(posedge clk);
    rx_frame.valid <= 1'b0;
    @(posedge clk);
    chk("rx match", {31'h0, e}, {31'h0, rx_match});
  endtask

  task automatic t_reset_values();
    for (int p = 0; p < 3; p++)
    begin
      pick(p[1:0], BANK_RX);
      rd_chk("parse default", OFS_RX_PARSE, 32'h0000_7018);
      pick(p[1:0], BANK_GENERAL);
      rd_chk("latency slot", OFS_RX_PARSE, 32'h0);
      rd_chk("delay default", OFS_ASYM_PEER, 32'h0);
      rd_chk("count default", OFS_CAP_INFO, 32'h0);
    end
    rd_chk("unmapped", 16'h0200, 32'h0);
    wr(OFS_BANK_SEL, 32'hFFFF_FFFF);
    rd_chk("bank select", OFS_BANK_SEL, 32'h0000_0737);
    rd_chk("reserved bank", OFS_ASYM_PEER, 32'h0);
  endtask

  task automatic t_delays();
    logic [31:0] q;
    pick(2'h2, BANK_GENERAL);
    wr(OFS_ASYM_PEER, 32'hFF38_01F4);
    wb(1'b1, OFS_ASYM_PEER, 32'h0000_00AA, 4'h1, q);
    rd_chk("asym peer", OFS_ASYM_PEER, 32'hFF38_01AA);
    pick(2'h3, BANK_GENERAL);
    wr(OFS_ASYM_PEER, 32'h1234_5678);
    rd_chk("port three", OFS_ASYM_PEER, 32'h0);
    pick(2'h0, BANK_GENERAL);
    rd_chk("other port", OFS_ASYM_PEER, 32'h0);
    dly_port <= 2'h2;
    repeat (2) @(posedge clk);
    chk("asym out", 32'hFFFF_FF38, 32'($signed(dly_asym)));
    chk("peer out", 32'h0000_01AA, {16'h0, dly_peer});
    dly_port <= 2'h0;
    repeat (2) @(posedge clk);
    chk("asym port0", 32'h0, {dly_asym, dly_peer});
  endtask

  // Parse enables change only while the global enable is clear
  task automatic set_parse(input logic [31:0] v);
    wr(OFS_CMD_CTL, 32'h0);
    pick(2'h1, BANK_RX);
    wr(OFS_RX_PARSE, v);
    wr(OFS_CMD_CTL, 32'h1);
  endtask

  task automatic t_parse();
    logic [127:0] v4p;
    logic [127:0] v4a;
    v4p = {96'h0, IP4_PRI};
    v4a = {96'h0, IP4_ALT1};
    pick(2'h1, BANK_RX);
    wr(OFS_RX_PARSE, 32'hFFFF_FFFF);
    rd_chk("parse mask", OFS_RX_PARSE, 32'h0000_7818);
    wr(OFS_RX_PARSE, 32'h0000_7018);
    frame(2'h1, KIND_IPV4, MAC_V4_PRI, v4p, 1'b0);
    wr(OFS_CMD_CTL, 32'h1);
    rd_chk("timing enable", OFS_CMD_CTL, 32'h1);
    chk("enable out", 32'h1, {31'h0, timing_en});
    frame(2'h1, KIND_L2, MAC_L2_PEER, 128'h0, 1'b1);
    frame(2'h1, KIND_L2, MAC_L2_GEN, 128'h0, 1'b1);
    frame(2'h1, KIND_IPV4, MAC_V4_PRI, v4p, 1'b1);
    frame(2'h1, KIND_IPV6, MAC_V6_PRI, {IP6_HEAD, 4'hE, IP6_PRI_TAIL}, 1'b1);
    frame(2'h1, KIND_IPV4, MAC_V4_ALT1, v4a, 1'b0);
    frame(2'h1, KIND_IPV6, MAC_V6_ALT1, {IP6_HEAD, 4'h2, IP6_ALT1_TAIL}, 1'b0);
    frame(2'h1, KIND_IPV4, MAC_V4_PRI, v4a, 1'b0);
    frame(2'h1, KIND_L2, 48'h0180_C200_0001, 128'h0, 1'b0);
    frame(2'h3, KIND_L2, MAC_L2_GEN, 128'h0, 1'b0);
    frame(2'h1, KIND_OTHER, MAC_L2_PEER, 128'h0, 1'b0);
    set_parse(32'h0000_3818);
    frame(2'h1, KIND_L2, MAC_L2_PEER, 128'h0, 1'b0);
    frame(2'h1, KIND_IPV4, MAC_V4_ALT1, v4a, 1'b1);
    frame(2'h1, KIND_IPV6, MAC_V6_ALT1, {IP6_HEAD, 4'h5, IP6_ALT1_TAIL}, 1'b1);
    cnt_chk(2'h1, 3'h0, 3'h6);
    cnt_chk(2'h0, 3'h0, 3'h0);
    set_parse(32'h0000_3808);
    frame(2'h1, KIND_IPV4, MAC_V4_PRI, v4a, 1'b1);
    set_parse(32'h0000_3800);
    frame(2'h1, KIND_L2, 48'h0180_C200_0001, 128'h0, 1'b1);
    cnt_chk(2'h1, 3'h0, 3'h7);
  endtask

  task automatic t_counts();
    tx_port <= 2'h2;
    tx_sent <= 1'b1;
    repeat (8) @(posedge clk);
    tx_sent <= 1'b0;
    @(posedge clk);
    cnt_chk(2'h2, 3'h7, 3'h0);
    wr(OFS_CAP_INFO, 32'hFFFF_FFFF);
    wr(OFS_EVT_CLR, 32'h0000_0040);
    cnt_chk(2'h2, 3'h6, 3'h0);
    wr(OFS_EVT_CLR, 32'h0000_0002);
    cnt_chk(2'h1, 3'h0, 3'h6);
    wr(OFS_EVT_CLR, 32'h0000_0011);
    cnt_chk(2'h0, 3'h0, 3'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    num_errors = 0;
    compares = 0;
    rst = 1'b1;
    adr = 16'h0;
    dat_w = 32'h0;
    sel = 4'h0;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    rx_frame = '0;
    tx_sent = 1'b0;
    tx_port = 2'h0;
    dly_port = 2'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_delays();
    t_parse();
    t_counts();
    tally_and_finish();
  end
endmodule
